/* File: adc_gain_rate_input_select_regs.sv */
// Amplifier, data rate, input pair and offset calibration register bank
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg_defines.svh"

module adc_gain_rate_input_select_regs #(
   parameter int ADDR_WIDTH = 8
) (
   // Clock, reset, enable
   input  wire logic                   clock,
   input  wire logic                   rst,
   input  wire logic                   ce,
   // AXI4-Lite write channels
   input  wire logic [ADDR_WIDTH-1:0]  awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   // AXI4-Lite read channels
   input  wire logic [ADDR_WIDTH-1:0]  araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   // Decoded settings toward the analog front end
   output var adc_cfg_pkg::amp_config_t  amp_cfg,
   output var adc_cfg_pkg::rate_config_t rate_cfg,
   output var adc_cfg_pkg::input_route_t pos_route,
   output var adc_cfg_pkg::input_route_t neg_route,
   output var logic [2:0]                filter_mode,
   output var logic [23:0]               offset_cal
);

   // Register contents
   logic [2:0] filter_sel;         // Digital filter selection
   logic [7:0] gain_and_rate_config; // Bypass, gain, rate
   logic [7:0] input_pair_select;  // Positive and negative select
   logic [7:0] ofs_byte [3];       // Offset calibration bytes

   // Register-side bus signals
   logic       reg_wr_en;          // Accepted low-lane write
   logic [7:0] reg_wr_idx;         // Write register index
   logic [7:0] reg_wr_data;        // Write byte
   logic [7:0] reg_rd_idx;         // Read register index
   logic [7:0] reg_rd_data;        // Read byte
   logic       reg_wr_ok;          // Write index mapped
   logic       reg_rd_ok;          // Read index mapped

   // Decoded combinational routes
   adc_cfg_pkg::input_route_t pos_dec; // Positive route
   adc_cfg_pkg::input_route_t neg_dec; // Negative route

   // Field views
   wire [3:0] pos_input_sel   = input_pair_select[`POS_MSB:`POS_LSB];
   wire [3:0] neg_input_sel   = input_pair_select[`NEG_MSB:`NEG_LSB];
   wire [2:0] gain_code       = gain_and_rate_config[`GAIN_MSB:`GAIN_LSB];
   wire [3:0] output_rate_sel = gain_and_rate_config[`RATE_MSB:`RATE_LSB];
   wire       amp_bypass      = gain_and_rate_config[`BYPASS_BIT];

   // Write decode per register
   wire wr_filter = reg_wr_en & (reg_wr_idx == `IDX_FILTER);
   wire wr_gain   = reg_wr_en & (reg_wr_idx == `IDX_GAIN_RATE);
   wire wr_input  = reg_wr_en & (reg_wr_idx == `IDX_INPUT);

   // Status conditions
   wire gain_reserved = (gain_code > `GAIN_MAX);
   wire fir_mode      = (filter_sel == `FILTER_FIR);
   wire fir_rate_ok   = (output_rate_sel == `RATE_2P5) |
                        (output_rate_sel == `RATE_5)   |
                        (output_rate_sel == `RATE_10)  |
                        (output_rate_sel == `RATE_20);
   wire rate_fault    = fir_mode & ~fir_rate_ok;
   wire [7:0] status  = {6'h00, rate_fault, gain_reserved};

   // Writable indices, status is read only
   assign reg_wr_ok = (reg_wr_idx == `IDX_FILTER) |
                      (reg_wr_idx == `IDX_GAIN_RATE) |
                      (reg_wr_idx == `IDX_INPUT) |
                      (reg_wr_idx == `IDX_OFS_LOW) |
                      (reg_wr_idx == `IDX_OFS_MID) |
                      (reg_wr_idx == `IDX_OFS_HIGH);

   // Readable indices
   assign reg_rd_ok = (reg_rd_idx == `IDX_FILTER) |
                      (reg_rd_idx == `IDX_GAIN_RATE) |
                      (reg_rd_idx == `IDX_INPUT) |
                      (reg_rd_idx == `IDX_OFS_LOW) |
                      (reg_rd_idx == `IDX_OFS_MID) |
                      (reg_rd_idx == `IDX_OFS_HIGH) |
                      (reg_rd_idx == `IDX_STATUS);

   // Read data selection
   assign reg_rd_data =
      (reg_rd_idx == `IDX_FILTER)    ? {5'h00, filter_sel} :
      (reg_rd_idx == `IDX_GAIN_RATE) ? gain_and_rate_config :
      (reg_rd_idx == `IDX_INPUT)     ? input_pair_select :
      (reg_rd_idx == `IDX_OFS_LOW)   ? ofs_byte[0] :
      (reg_rd_idx == `IDX_OFS_MID)   ? ofs_byte[1] :
      (reg_rd_idx == `IDX_OFS_HIGH)  ? ofs_byte[2] :
      (reg_rd_idx == `IDX_STATUS)    ? status : 8'h00;

   // Bus front end
   adc_cfg_axil_slave #(
      .ADDR_WIDTH (ADDR_WIDTH)
   ) u_bus (
      .clock       (clock),
      .rst         (rst),
      .ce          (ce),
      .awaddr      (awaddr),
      .awvalid     (awvalid),
      .awready     (awready),
      .wdata       (wdata),
      .wstrb       (wstrb),
      .wvalid      (wvalid),
      .wready      (wready),
      .bresp       (bresp),
      .bvalid      (bvalid),
      .bready      (bready),
      .araddr      (araddr),
      .arvalid     (arvalid),
      .arready     (arready),
      .rdata       (rdata),
      .rresp       (rresp),
      .rvalid      (rvalid),
      .rready      (rready),
      .reg_wr_en   (reg_wr_en),
      .reg_wr_idx  (reg_wr_idx),
      .reg_wr_data (reg_wr_data),
      .reg_wr_ok   (reg_wr_ok),
      .reg_rd_idx  (reg_rd_idx),
      .reg_rd_data (reg_rd_data),
      .reg_rd_ok   (reg_rd_ok)
   );

   // Filter selection register
   // FIR filter by default
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         filter_sel <= `RST_FILTER;
      end else if (ce && wr_filter) begin
         filter_sel <= reg_wr_data[2:0];
      end
   end

   // Gain and rate register, reserved codes kept as written
   // Reset and index
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         gain_and_rate_config <= `RST_GAIN_RATE;
      end else if (ce && wr_gain) begin
         gain_and_rate_config <= reg_wr_data;
      end
   end

   // Input pair register
   // Pin 0 positive, pin 1 negative
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         input_pair_select <= `RST_INPUT;
      end else if (ce && wr_input) begin
         input_pair_select <= reg_wr_data;
      end
   end

   // Offset calibration bytes, one per index
   for (genvar i = 0; i < 3; i++) begin : g_ofs
      // This byte's index
      wire [7:0] my_idx = 8'(`IDX_OFS_LOW + i);
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            ofs_byte[i] <= `RST_OFS;
         end else if (ce && reg_wr_en && reg_wr_idx == my_idx) begin
            ofs_byte[i] <= reg_wr_data;
         end
      end
   end

   // Positive input decoder
   // Pin and common coding
   adc_input_route_decode u_pos (
      .code  (pos_input_sel),
      .route (pos_dec)
   );

   // Negative input decoder
   // Same coding as positive
   adc_input_route_decode u_neg (
      .code  (neg_input_sel),
      .route (neg_dec)
   );

   // Registered amplifier outputs
   // Bypass bit drives path
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         amp_cfg <= '{bypass: 1'b0, gain_code: 3'h0, gain_factor: 6'h01,
                      gain_reserved: 1'b0};
      end else if (ce) begin
         amp_cfg.bypass        <= amp_bypass;
         amp_cfg.gain_code     <= gain_code;
         amp_cfg.gain_factor   <= gain_reserved ? 6'h00 : 6'(6'h01 << gain_code);
         amp_cfg.gain_reserved <= gain_reserved;
      end
   end

   // Registered rate outputs
   // Rate code and FIR check
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rate_cfg <= '{code: 4'h4, fir_mode: 1'b1, legal: 1'b1};
      end else if (ce) begin
         rate_cfg.code     <= output_rate_sel;
         rate_cfg.fir_mode <= fir_mode;
         rate_cfg.legal    <= ~rate_fault;
      end
   end

   // Registered routes, filter and offset word
   // Monitor routes follow decode
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pos_route   <= '{kind: adc_cfg_pkg::analog_pin, pin: 4'h0};
         neg_route   <= '{kind: adc_cfg_pkg::analog_pin, pin: 4'h1};
         filter_mode <= `RST_FILTER;
         offset_cal  <= 24'h000000;
      end else if (ce) begin
         pos_route   <= pos_dec;
         neg_route   <= neg_dec;
         filter_mode <= filter_sel;
         offset_cal  <= {ofs_byte[2], ofs_byte[1], ofs_byte[0]};
      end
   end

   // Checks on the bank's behaviour

   property p_bypass;
      @(posedge clock) disable iff (rst)
      ce |=> amp_cfg.bypass == $past(amp_bypass);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass output does not follow bit 7");

   property p_gain;
      @(posedge clock) disable iff (rst)
      (ce && gain_code <= `GAIN_MAX) |=>
         amp_cfg.gain_factor == 6'(6'h01 << $past(gain_code)) && !amp_cfg.gain_reserved;
   endproperty
   a_gain: assert property (p_gain)
      else $error("gain factor is not the power of two of the code");

   property p_rate;
      @(posedge clock) disable iff (rst)
      ce |=> rate_cfg.code == $past(output_rate_sel);
   endproperty
   a_rate: assert property (p_rate)
      else $error("rate output does not follow the rate field");

   property p_fir_limit;
      @(posedge clock) disable iff (rst)
      (ce && fir_mode && (output_rate_sel == 4'h3 || output_rate_sel > 4'h4))
         |=> !rate_cfg.legal;
   endproperty
   a_fir_limit: assert property (p_fir_limit)
      else $error("fast rate under FIR not flagged");

   property p_pos_common;
      @(posedge clock) disable iff (rst)
      (ce && pos_input_sel == `SEL_COMMON) |=> pos_route.kind == adc_cfg_pkg::common_input_pin;
   endproperty
   a_pos_common: assert property (p_pos_common)
      else $error("positive common code not routed to common pin");

   property p_pos_monitor;
      @(posedge clock) disable iff (rst)
      (ce && pos_input_sel == `SEL_TEST) |=>
         pos_route.kind == adc_cfg_pkg::test_signal_source ##1 1'b1;
   endproperty
   a_pos_monitor: assert property (p_pos_monitor)
      else $error("positive test code not routed to test signal");

   property p_neg_pin;
      @(posedge clock) disable iff (rst)
      (ce && neg_input_sel <= `SEL_LAST_PIN) |=>
         neg_route.kind == adc_cfg_pkg::analog_pin && neg_route.pin == $past(neg_input_sel);
   endproperty
   a_neg_pin: assert property (p_neg_pin)
      else $error("negative pin code not routed to its pin");

   property p_neg_float;
      @(posedge clock) disable iff (rst)
      (ce && neg_input_sel == `SEL_FLOAT) |=> neg_route.kind == adc_cfg_pkg::floating_input;
   endproperty
   a_neg_float: assert property (p_neg_float)
      else $error("negative float code not left open");

   property p_input_reset;
      @(posedge clock) disable iff (rst)
      $past(rst) |-> input_pair_select == `RST_INPUT && pos_route.pin == 4'h0
         && neg_route.pin == 4'h1;
   endproperty
   a_input_reset: assert property (p_input_reset)
      else $error("input select not at pin 0 and pin 1 after reset");

   property p_ofs_write;
      @(posedge clock) disable iff (rst)
      (ce && reg_wr_en && reg_wr_idx == `IDX_OFS_HIGH) |=>
         ofs_byte[2] == $past(reg_wr_data) ##1 (!ce || offset_cal[23:16] == $past(ofs_byte[2]));
   endproperty
   a_ofs_write: assert property (p_ofs_write)
      else $error("offset high byte write not stored");

   property p_gain_read;
      @(posedge clock) disable iff (rst)
      (arvalid && arready && reg_rd_idx == `IDX_GAIN_RATE) |=>
         rvalid && rdata == {24'h000000, $past(gain_and_rate_config)};
   endproperty
   a_gain_read: assert property (p_gain_read)
      else $error("gain and rate register read back wrong");

   property p_filter_reset;
      @(posedge clock) disable iff (rst)
      $past(rst) |-> filter_sel == `FILTER_FIR && rate_cfg.fir_mode;
   endproperty
   a_filter_reset: assert property (p_filter_reset)
      else $error("filter not FIR after reset");

endmodule : adc_gain_rate_input_select_regs
`default_nettype wire

/* File: adc_cfg_defines.svh */
// Register indices, field positions, reset values and codes of the config bank
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH

// Register indices, byte address is four times the index
`define IDX_FILTER     8'h04
`define IDX_GAIN_RATE  8'h05
`define IDX_INPUT      8'h06
`define IDX_OFS_LOW    8'h07
`define IDX_OFS_MID    8'h08
`define IDX_OFS_HIGH   8'h09
`define IDX_STATUS     8'h0F

// Reset values
`define RST_FILTER     3'h4
`define RST_GAIN_RATE  8'h04
`define RST_INPUT      8'h01
`define RST_OFS        8'h00

// Field positions
`define BYPASS_BIT     7
`define GAIN_MSB       6
`define GAIN_LSB       4
`define RATE_MSB       3
`define RATE_LSB       0
`define POS_MSB        7
`define POS_LSB        4
`define NEG_MSB        3
`define NEG_LSB        0

// Field codes
`define GAIN_MAX       3'h5
`define FILTER_FIR     3'h4
`define RATE_2P5       4'h0
`define RATE_5         4'h1
`define RATE_10        4'h2
`define RATE_20        4'h4
`define SEL_LAST_PIN   4'h9
`define SEL_COMMON     4'hA
`define SEL_TEMP       4'hB
`define SEL_ASUPPLY    4'hC
`define SEL_DSUPPLY    4'hD
`define SEL_TEST       4'hE
`define SEL_FLOAT      4'hF

// Bus answers
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

/* File: adc_cfg_pkg.sv */
// Types shared by the converter configuration bank
package adc_cfg_pkg;

   // Where one converter input is routed
   typedef enum logic [2:0] {
      analog_pin, common_input_pin, temp_sensor, analog_supply,
      digital_supply, test_signal_source, floating_input
   } input_kind_t;

   // Decoded input route
   typedef struct packed {
      input_kind_t kind;
      logic [3:0]  pin;
   } input_route_t;

   // Decoded amplifier settings
   typedef struct packed {
      logic       bypass;
      logic [2:0] gain_code;
      logic [5:0] gain_factor;
      logic       gain_reserved;
   } amp_config_t;

   // Decoded rate settings
   typedef struct packed {
      logic [3:0] code;
      logic       fir_mode;
      logic       legal;
   } rate_config_t;

endpackage : adc_cfg_pkg

/* File: adc_input_route_decode.sv */
// Decoder from a four-bit input select code to a route
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg_defines.svh"

module adc_input_route_decode (
   // Select code
   input  wire logic [3:0]              code,
   // Decoded route
   output adc_cfg_pkg::input_route_t    route
);

   // Codes up to the last pin select a numbered pin
   wire is_pin = (code <= `SEL_LAST_PIN);

   // Route kind by code
   assign route.kind = is_pin ? adc_cfg_pkg::analog_pin :
      (code == `SEL_COMMON)  ? adc_cfg_pkg::common_input_pin :
      (code == `SEL_TEMP)    ? adc_cfg_pkg::temp_sensor :
      (code == `SEL_ASUPPLY) ? adc_cfg_pkg::analog_supply :
      (code == `SEL_DSUPPLY) ? adc_cfg_pkg::digital_supply :
      (code == `SEL_TEST)    ? adc_cfg_pkg::test_signal_source :
                               adc_cfg_pkg::floating_input;

   // Pin number, zero when no numbered pin
   assign route.pin = is_pin ? code : 4'h0;

endmodule : adc_input_route_decode
`default_nettype wire

/* File: adc_cfg_axil_slave.sv */
// AXI4-Lite slave front end of the configuration bank
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg_defines.svh"

module adc_cfg_axil_slave #(
   parameter int ADDR_WIDTH = 8
) (
   // Clock, reset, enable
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  ce,
   // Write address and data
   input  wire logic [ADDR_WIDTH-1:0] awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   // Write response
   output var logic [1:0]             bresp,
   output var logic                   bvalid,
   input  wire logic                  bready,
   // Read address and data
   input  wire logic [ADDR_WIDTH-1:0] araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output var logic [31:0]            rdata,
   output var logic [1:0]             rresp,
   output var logic                   rvalid,
   input  wire logic                  rready,
   // Register side
   output logic                       reg_wr_en,
   output logic [7:0]                 reg_wr_idx,
   output logic [7:0]                 reg_wr_data,
   input  wire logic                  reg_wr_ok,
   output logic [7:0]                 reg_rd_idx,
   input  wire logic [7:0]            reg_rd_data,
   input  wire logic                  reg_rd_ok
);

   // Refuse address widths the index decode cannot serve
   if (ADDR_WIDTH < 6 || ADDR_WIDTH > 10) begin : g_bad_width
      $error("ADDR_WIDTH must lie between 6 and 10");
   end

   logic [ADDR_WIDTH-1:0] aw_addr_q;  // Held write address
   logic                  aw_held;    // Write address taken
   logic [7:0]            w_data_q;   // Held low data byte
   logic                  w_lane_q;   // Low byte lane enabled
   logic                  w_held;     // Write data taken

   // Both halves present and no response pending
   wire write_go = ce & aw_held & w_held & ~bvalid;

   // Handshake and register-side decode
   assign awready     = ce & ~aw_held;
   assign wready      = ce & ~w_held;
   assign arready     = ce & ~rvalid;
   assign reg_wr_en   = write_go & reg_wr_ok & w_lane_q;
   assign reg_wr_idx  = 8'(aw_addr_q >> 2);
   assign reg_wr_data = w_data_q;
   assign reg_rd_idx  = 8'(araddr >> 2);

   // Address and data capture, either order
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         aw_held   <= 1'b0;
         aw_addr_q <= '0;
         w_held    <= 1'b0;
         w_data_q  <= 8'h00;
         w_lane_q  <= 1'b0;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_held   <= 1'b1;
            aw_addr_q <= awaddr;
         end else if (write_go) begin
            aw_held <= 1'b0;
         end
         if (wvalid && wready) begin
            w_held   <= 1'b1;
            w_data_q <= wdata[7:0];
            w_lane_q <= wstrb[0];
         end else if (write_go) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp  <= `RESP_OKAY;
      end else if (ce) begin
         if (write_go) begin
            bvalid <= 1'b1;
            bresp  <= reg_wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Read answer, narrow data in the low byte
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= `RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= reg_rd_ok ? {24'h000000, reg_rd_data} : 32'h00000000;
            rresp  <= reg_rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

endmodule : adc_cfg_axil_slave
`default_nettype wire

/* File: tb_adc_gain_rate_input_select_regs.sv */
// Self-checking bench of the converter configuration register bank
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg_defines.svh"

module tb_adc_gain_rate_input_select_regs;
   // Clock, reset and bus drive
   logic                       clock   = 1'b0;
   logic                       rst     = 1'b1;
   logic                       ce      = 1'b1;
   logic [7:0]                 awaddr  = 8'h00;
   logic [7:0]                 araddr  = 8'h00;
   logic                       awvalid = 1'b0;
   logic                       wvalid  = 1'b0;
   logic                       arvalid = 1'b0;
   logic                       bready  = 1'b1;
   logic                       rready  = 1'b1;
   logic [31:0]                wdata   = 32'h0;
   logic [3:0]                 wstrb   = 4'hF;
   // Design answers
   logic                       awready, wready, bvalid, arready, rvalid;
   logic [1:0]                 bresp, rresp;
   logic [31:0]                rdata;
   adc_cfg_pkg::amp_config_t   amp_cfg;
   adc_cfg_pkg::rate_config_t  rate_cfg;
   adc_cfg_pkg::input_route_t  pos_route, neg_route;
   logic [2:0]                 filter_mode;
   logic [23:0]                offset_cal;
   // Bookkeeping
   int                         errors = 0;
   int                         n_checks = 0;
   int                         cycles = 0;
   logic [31:0]                rd_val;
   logic [1:0]                 rd_resp, wr_resp;

   adc_gain_rate_input_select_regs #(.ADDR_WIDTH(8)) adc_gain_rate_input_select_regs_inst (
      .clock(clock), .rst(rst), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .amp_cfg(amp_cfg), .rate_cfg(rate_cfg), .pos_route(pos_route), .neg_route(neg_route),
      .filter_mode(filter_mode), .offset_cal(offset_cal));

   // Free-running clock
   always #4 clock = ~clock;

   // Verdict and end of run
   task automatic close_out();
      if (errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out

   // Compare one value
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Bus write; ready sampled at the falling edge before each rising edge
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic aw, w, a, b;
      aw = 1'b1;
      w = 1'b1;
      awaddr <= {idx[5:0], 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (aw || w) begin
         @(negedge clock);
         a = awready;
         b = wready;
         @(posedge clock);
         if (a === 1'b1 && aw) begin
            awvalid <= 1'b0;
            aw = 1'b0;
         end
         if (b === 1'b1 && w) begin
            wvalid <= 1'b0;
            w = 1'b0;
         end
      end
      do begin
         @(negedge clock);
         a = bvalid;
         wr_resp = bresp;
         @(posedge clock);
      end while (a !== 1'b1);
      // Decoded outputs trail the store by one edge
      repeat (2) @(posedge clock);
   endtask : wr

   // Bus read
   task automatic rd(input logic [7:0] idx);
      logic a;
      araddr <= {idx[5:0], 2'b00};
      arvalid <= 1'b1;
      do begin
         @(negedge clock);
         a = arready;
         @(posedge clock);
      end while (a !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(negedge clock);
         a = rvalid;
         rd_val = rdata;
         rd_resp = rresp;
         @(posedge clock);
      end while (a !== 1'b1);
   endtask : rd

   // Read and compare, answer must be OKAY
   task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
      rd(idx);
      check("rdata", rd_val, exp);
      check("rresp", 32'(rd_resp), 32'(`RESP_OKAY));
   endtask : rc

   // Expected route word: kind above a four-bit pin
   function automatic logic [31:0] route(input int c);
      return (c <= 9) ? 32'(c) : 32'((c - 9) << 4);
   endfunction : route

   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         close_out();
      end
   end

   // Main sequence
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rc(`IDX_GAIN_RATE, 32'h04);
      rc(`IDX_INPUT, 32'h01);
      for (int i = 7; i <= 9; i++) rc(8'(i), 32'h0);
      check("amp", 32'(amp_cfg), 32'h002);
      check("pos", 32'(pos_route), 32'h0);
      check("neg", 32'(neg_route), 32'h1);
      check("filter", 32'(filter_mode), 32'h4);
      // Every gain code, bypass alternating
      for (int g = 0; g < 8; g++) begin
         wr(`IDX_GAIN_RATE, {g[0], g[2:0], 4'h4});
         rc(`IDX_GAIN_RATE, {24'h0, g[0], g[2:0], 4'h4});
         check("amp", 32'(amp_cfg), {21'h0, g[0], g[2:0], (g < 6) ? 6'(1 << g) : 6'h00, g >= 6});
      end
      rc(`IDX_STATUS, 32'h01);
      // Every rate code under the FIR filter
      for (int r = 0; r < 16; r++) begin
         wr(`IDX_GAIN_RATE, {4'h0, r[3:0]});
         check("rate", 32'(rate_cfg), {26'h0, r[3:0], 1'b1, r inside {0, 1, 2, 4}});
      end
      rc(`IDX_STATUS, 32'h02);
      // Other filter lifts the limit
      wr(`IDX_FILTER, 8'h00);
      wr(`IDX_GAIN_RATE, 8'h03);
      check("rate", 32'(rate_cfg), 32'h0D);
      check("filter", 32'(filter_mode), 32'h0);
      rc(`IDX_FILTER, 32'h0);
      // Low byte lane off: answered OKAY, nothing stored
      wstrb <= 4'hE;
      wr(`IDX_GAIN_RATE, 8'hFF);
      check("bresp", 32'(wr_resp), 32'(`RESP_OKAY));
      wstrb <= 4'hF;
      rc(`IDX_GAIN_RATE, 32'h03);
      // Every select code on both inputs
      for (int c = 0; c < 16; c++) begin
         wr(`IDX_INPUT, {c[3:0], ~c[3:0]});
         check("pos", 32'(pos_route), route(c));
         check("neg", 32'(neg_route), route(15 - c));
      end
      // Offset word assembly
      wr(`IDX_OFS_LOW, 8'hA5);
      wr(`IDX_OFS_MID, 8'h3C);
      wr(`IDX_OFS_HIGH, 8'h81);
      check("offset", 32'(offset_cal), 32'h813CA5);
      check("bresp", 32'(wr_resp), 32'(`RESP_OKAY));
      // Enable low drops every ready
      ce <= 1'b0;
      @(negedge clock);
      check("ready", 32'({awready, wready, arready}), 32'h0);
      @(posedge clock);
      ce <= 1'b1;
      // Unmapped index refused
      rd(8'h10);
      check("rresp", 32'(rd_resp), 32'(`RESP_SLVERR));
      check("rdata", rd_val, 32'h0);
      wr(8'h10, 8'hFF);
      check("bresp", 32'(wr_resp), 32'(`RESP_SLVERR));
      // Status is read only
      wr(`IDX_STATUS, 8'h00);
      check("bresp", 32'(wr_resp), 32'(`RESP_SLVERR));
      close_out();
   end
endmodule : tb_adc_gain_rate_input_select_regs
`default_nettype wire
